/* File: src/bit_branch_clear_exec.sv */
// What this block does
// - Bit toggle inverts one bit of a data byte: read, modify, write back.
// - Access-select 0 picks the access bank; 1 uses the bank select register.
// - Extended set with access-select 0 and operand up to 5Fh: indexed offset.
// - Branch offset is signed eight bits, doubled before adding to PC.
// - Overflow set: PC becomes incremented PC plus twice offset; else next.
// - Branch takes one cycle, or two when taken; extra cycle does nothing.
// - Clear writes zero to the data byte and sets only the zero flag.
// - Watchdog clear zeroes counter and postscaler, sets timeout and power flags.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
module bit_branch_clear_exec
   import exec_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // APB slave
   input apb_req_type apb_req_i,
   output apb_rsp_type apb_rsp_o
);

   // ****************************************
   // State
   // ****************************************
   logic [7:0] mem [0:4095];
   apb_rsp_type rsp_r, rsp_nxt;
   logic [15:0] opcode_r, opcode_nxt;
   logic ext_en_r, ext_en_nxt;
   logic [3:0] bank_select_reg_r, bank_select_reg_nxt;
   logic ovf_r, ovf_nxt;
   logic zero_r, zero_nxt;
   logic timeout_flag_r, timeout_flag_nxt;
   logic powerdown_flag_r, powerdown_flag_nxt;
   logic [20:0] pc_r, pc_nxt;
   logic [11:0] index_r, index_nxt;
   logic [11:0] mem_addr_r, mem_addr_nxt;
   op_kind_type kind_r, kind_nxt;
   logic [11:0] ea_r, ea_nxt;
   logic [7:0] operand_r, operand_nxt;
   logic [7:0] result_r, result_nxt;
   logic [20:0] target_r, target_nxt;
   logic [7:0] watchdog_counter_r, watchdog_counter_nxt;
   logic [7:0] wd_post_r, wd_post_nxt;

   phase_type phase;
   logic nop_cycle;
   logic busy;
   logic start;
   logic extra;
   logic access;
   logic commit;
   logic mem_we;
   logic [11:0] mem_wa;
   logic [7:0] mem_wd;
   logic wd_clear;
   logic [7:0] toggle_mask;

   assign busy = (phase != PH_IDLE);
   assign access = apb_req_i.psel && apb_req_i.penable;
   // A write lands only at the edge where pready is seen high
   assign commit = access && apb_req_i.pwrite && rsp_r.pready
      && !rsp_r.pslverr;
   assign start = commit && (apb_req_i.paddr == REG_INSTR);
   assign toggle_mask = BIT_ONE << opcode_r[11:9];

   quarter_phase_seq u_seq
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .start_i(start),
      .extra_i(extra),
      .phase_o(phase),
      .nop_cycle_o(nop_cycle)
   );

   // ****************************************
   // Decode helpers
   // ****************************************
   function automatic op_kind_type decode_op(input logic [15:0] op);
      op_kind_type k;
      k = OP_NONE;
      if ((op & OPC_TOGGLE_MASK) == OPC_TOGGLE_VAL)
         k = OP_TOGGLE;
      else if ((op & OPC_CLEAR_MASK) == OPC_CLEAR_VAL)
         k = OP_CLEAR;
      else if ((op & OPC_BRANCH_MASK) == OPC_BRANCH_VAL)
         k = OP_BRANCH;
      else if (op == OPC_WDOG_CLEAR)
         k = OP_WDOG_CLEAR;
      return k;
   endfunction

   function automatic logic [11:0] eff_addr(input logic a,
      input logic [7:0] f, input logic ext, input logic [3:0] bank,
      input logic [11:0] idx);
      logic [11:0] ea;
      ea = {bank, f};
      if (!a)
      begin
         if (ext && (f <= INDEXED_LIMIT))
            ea = idx + {4'h0, f};
         else if (f <= INDEXED_LIMIT)
            ea = {ACCESS_LOW_BANK, f};
         else
            ea = {ACCESS_HIGH_BANK, f};
      end
      return ea;
   endfunction

   // ****************************************
   // Instruction execution
   // ****************************************
   always_comb
   begin
      kind_nxt = kind_r;
      ea_nxt = ea_r;
      operand_nxt = operand_r;
      result_nxt = result_r;
      target_nxt = target_r;
      pc_nxt = pc_r;
      zero_nxt = zero_r;
      ovf_nxt = ovf_r;
      extra = 1'b0;
      wd_clear = 1'b0;
      mem_we = 1'b0;
      mem_wa = ea_r;
      mem_wd = result_r;
      // The appended branch cycle leaves every phase idle
      if (!nop_cycle)
      begin
         case (phase)
            PH_Q1:
            begin
               kind_nxt = decode_op(opcode_r);
               ea_nxt = eff_addr(opcode_r[8], opcode_r[7:0], ext_en_r,
                  bank_select_reg_r, index_r);
               pc_nxt = pc_r + PC_STEP;
            end
            PH_Q2:
               operand_nxt = mem[ea_r];
            PH_Q3:
            begin
               case (kind_r)
                  OP_TOGGLE: result_nxt = operand_r ^ toggle_mask;
                  OP_CLEAR: result_nxt = BYTE_ZERO;
                  OP_BRANCH: target_nxt = pc_r
                     + {{12{opcode_r[7]}}, opcode_r[7:0], 1'b0};
                  OP_WDOG_CLEAR: wd_clear = 1'b1;
                  default: result_nxt = result_r;
               endcase
            end
            PH_Q4:
            begin
               case (kind_r)
                  OP_TOGGLE: mem_we = 1'b1;
                  OP_CLEAR:
                  begin
                     mem_we = 1'b1;
                     zero_nxt = FLAG_SET;
                  end
                  OP_BRANCH:
                  begin
                     if (ovf_r)
                     begin
                        pc_nxt = target_r;
                        extra = 1'b1;
                     end
                  end
                  default: mem_we = 1'b0;
               endcase
            end
            default: kind_nxt = kind_r;
         endcase
      end
      // Software changes are refused while busy, so no clash with Q4
      if (commit && (apb_req_i.paddr == REG_STATUS))
      begin
         ovf_nxt = apb_req_i.pwdata[ST_OVF_BIT];
         zero_nxt = apb_req_i.pwdata[ST_ZERO_BIT];
      end
      if (commit && (apb_req_i.paddr == REG_PC))
         pc_nxt = apb_req_i.pwdata[20:0];
      if (commit && (apb_req_i.paddr == REG_MEM_DATA))
      begin
         mem_we = 1'b1;
         mem_wa = mem_addr_r;
         mem_wd = apb_req_i.pwdata[7:0];
      end
   end

   // ****************************************
   // Watchdog
   // ****************************************
   always_comb
   begin
      watchdog_counter_nxt = watchdog_counter_r + 8'h01;
      wd_post_nxt = wd_post_r;
      timeout_flag_nxt = timeout_flag_r;
      powerdown_flag_nxt = powerdown_flag_r;
      if (watchdog_counter_r == 8'hFF)
         wd_post_nxt = wd_post_r + 8'h01;
      if (wd_clear)
      begin
         watchdog_counter_nxt = BYTE_ZERO;
         wd_post_nxt = BYTE_ZERO;
         timeout_flag_nxt = FLAG_SET;
         powerdown_flag_nxt = FLAG_SET;
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   always_comb
   begin
      rsp_nxt = rsp_r;
      opcode_nxt = opcode_r;
      ext_en_nxt = ext_en_r;
      bank_select_reg_nxt = bank_select_reg_r;
      index_nxt = index_r;
      mem_addr_nxt = mem_addr_r;
      rsp_nxt.pready = access && !rsp_r.pready;
      if (access && !rsp_r.pready)
      begin
         rsp_nxt.prdata = WORD_ZERO;
         // Unmapped addresses and writes during execution both error
         rsp_nxt.pslverr = apb_req_i.pwrite && busy
            && (apb_req_i.paddr != REG_WDOG);
         case (apb_req_i.paddr)
            REG_INSTR: rsp_nxt.prdata[15:0] = opcode_r;
            REG_CTRL:
            begin
               rsp_nxt.prdata[CTRL_EXT_BIT] = ext_en_r;
               rsp_nxt.prdata[CTRL_BANK_LSB +: 4] = bank_select_reg_r;
            end
            REG_STATUS:
            begin
               rsp_nxt.prdata[ST_OVF_BIT] = ovf_r;
               rsp_nxt.prdata[ST_ZERO_BIT] = zero_r;
               rsp_nxt.prdata[ST_TIMEOUT_BIT] = timeout_flag_r;
               rsp_nxt.prdata[ST_PDOWN_BIT] = powerdown_flag_r;
               rsp_nxt.prdata[ST_BUSY_BIT] = busy;
            end
            REG_PC: rsp_nxt.prdata[20:0] = pc_r;
            REG_INDEX: rsp_nxt.prdata[11:0] = index_r;
            REG_MEM_ADDR: rsp_nxt.prdata[11:0] = mem_addr_r;
            REG_MEM_DATA: rsp_nxt.prdata[7:0] = mem[mem_addr_r];
            REG_WDOG:
            begin
               rsp_nxt.prdata[7:0] = watchdog_counter_r;
               rsp_nxt.prdata[WDOG_POST_LSB +: 8] = wd_post_r;
               rsp_nxt.pslverr = apb_req_i.pwrite;
            end
            default: rsp_nxt.pslverr = 1'b1;
         endcase
      end
      if (commit)
      begin
         case (apb_req_i.paddr)
            REG_INSTR: opcode_nxt = apb_req_i.pwdata[15:0];
            REG_CTRL:
            begin
               ext_en_nxt = apb_req_i.pwdata[CTRL_EXT_BIT];
               bank_select_reg_nxt = apb_req_i.pwdata[CTRL_BANK_LSB +: 4];
            end
            REG_INDEX: index_nxt = apb_req_i.pwdata[11:0];
            REG_MEM_ADDR: mem_addr_nxt = apb_req_i.pwdata[11:0];
            default: index_nxt = index_r;
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clock_i)
   begin
      if (mem_we)
         mem[mem_wa] <= mem_wd;
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         rsp_r <= '0;
         opcode_r <= 16'h0000;
         ext_en_r <= 1'b0;
         bank_select_reg_r <= 4'h0;
         ovf_r <= 1'b0;
         zero_r <= 1'b0;
         timeout_flag_r <= FLAG_SET;
         powerdown_flag_r <= FLAG_SET;
         pc_r <= PC_RESET;
         index_r <= ADDR_ZERO;
         mem_addr_r <= ADDR_ZERO;
         kind_r <= OP_NONE;
         ea_r <= ADDR_ZERO;
         operand_r <= BYTE_ZERO;
         result_r <= BYTE_ZERO;
         target_r <= PC_RESET;
         watchdog_counter_r <= BYTE_ZERO;
         wd_post_r <= BYTE_ZERO;
      end
      else
      begin
         rsp_r <= rsp_nxt;
         opcode_r <= opcode_nxt;
         ext_en_r <= ext_en_nxt;
         bank_select_reg_r <= bank_select_reg_nxt;
         ovf_r <= ovf_nxt;
         zero_r <= zero_nxt;
         timeout_flag_r <= timeout_flag_nxt;
         powerdown_flag_r <= powerdown_flag_nxt;
         pc_r <= pc_nxt;
         index_r <= index_nxt;
         mem_addr_r <= mem_addr_nxt;
         kind_r <= kind_nxt;
         ea_r <= ea_nxt;
         operand_r <= operand_nxt;
         result_r <= result_nxt;
         target_r <= target_nxt;
         watchdog_counter_r <= watchdog_counter_nxt;
         wd_post_r <= wd_post_nxt;
      end
   end

   assign apb_rsp_o = rsp_r;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   AST_TOGGLE_WRITE: assert property (
      phase == PH_Q4 && !nop_cycle && kind_r == OP_TOGGLE
      |=> mem[ea_r] == ($past(operand_r) ^ $past(toggle_mask)))
      else $error("toggled byte wrong");
   AST_BANK_SELECT: assert property (
      phase == PH_Q2 && !nop_cycle && opcode_r[8]
      && (kind_r == OP_TOGGLE || kind_r == OP_CLEAR)
      |-> ea_r == {bank_select_reg_r, opcode_r[7:0]})
      else $error("bank select address wrong");
   AST_INDEXED: assert property (
      phase == PH_Q2 && !nop_cycle && !opcode_r[8] && ext_en_r
      && opcode_r[7:0] <= INDEXED_LIMIT
      |-> ea_r == index_r + {4'h0, opcode_r[7:0]})
      else $error("indexed address wrong");
   AST_BRANCH_TAKEN: assert property (
      phase == PH_Q1 && !nop_cycle && decode_op(opcode_r) == OP_BRANCH
      && ovf_r |-> ##4 pc_r == $past(pc_r, 4) + PC_STEP
         + {{12{opcode_r[7]}}, opcode_r[7:0], 1'b0})
      else $error("branch target wrong");
   AST_BRANCH_NOT_TAKEN: assert property (
      phase == PH_Q1 && !nop_cycle && decode_op(opcode_r) == OP_BRANCH
      && !ovf_r |-> ##4 pc_r == $past(pc_r, 4) + PC_STEP
         && phase == PH_IDLE)
      else $error("untaken branch wrong");
   // The branch target lands at the first empty cycle, so stability is
   // only required from the second one on
   AST_BRANCH_EXTRA: assert property (
      phase == PH_Q4 && !nop_cycle && kind_r == OP_BRANCH && ovf_r
      |=> nop_cycle ##1 (nop_cycle && $stable(ovf_r) && $stable(zero_r)
         && $stable(pc_r)) [*3] ##1 phase == PH_IDLE)
      else $error("taken branch extra cycle wrong");
   AST_CLEAR_ZERO: assert property (
      phase == PH_Q4 && !nop_cycle && kind_r == OP_CLEAR
      |=> mem[ea_r] == BYTE_ZERO && zero_r && $stable(ovf_r)
         && $stable(timeout_flag_r))
      else $error("clear register wrong");
   AST_WDOG_CLEAR: assert property (
      phase == PH_Q3 && !nop_cycle && kind_r == OP_WDOG_CLEAR
      |=> watchdog_counter_r == BYTE_ZERO && wd_post_r == BYTE_ZERO
         && timeout_flag_r && powerdown_flag_r && !mem_we)
      else $error("watchdog clear wrong");

   COV_TOGGLE: cover property (phase == PH_Q4 && kind_r == OP_TOGGLE);
   COV_CLEAR: cover property (phase == PH_Q4 && kind_r == OP_CLEAR);
   COV_BRANCH_TAKEN: cover property (nop_cycle && phase == PH_Q4);
   COV_WDOG_CLEAR: cover property (phase == PH_Q3
      && kind_r == OP_WDOG_CLEAR);

endmodule

/* File: src/exec_pkg.sv */
package exec_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [11:0] REG_INSTR = 12'h000;
   localparam logic [11:0] REG_CTRL = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_PC = 12'h00C;
   localparam logic [11:0] REG_INDEX = 12'h010;
   localparam logic [11:0] REG_MEM_ADDR = 12'h014;
   localparam logic [11:0] REG_MEM_DATA = 12'h018;
   localparam logic [11:0] REG_WDOG = 12'h01C;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int CTRL_EXT_BIT = 0;
   localparam int CTRL_BANK_LSB = 8;
   localparam int ST_OVF_BIT = 0;
   localparam int ST_ZERO_BIT = 1;
   localparam int ST_TIMEOUT_BIT = 2;
   localparam int ST_PDOWN_BIT = 3;
   localparam int ST_BUSY_BIT = 4;
   localparam int WDOG_POST_LSB = 8;
   localparam logic FLAG_SET = 1'b1;
   localparam logic [20:0] PC_RESET = 21'h00_0000;
   localparam logic [20:0] PC_STEP = 21'h00_0002;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BIT_ONE = 8'h01;
   localparam logic [11:0] ADDR_ZERO = 12'h000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ****************************************
   // Opcodes and addressing
   // ****************************************
   localparam logic [15:0] OPC_TOGGLE_MASK = 16'hF000;
   localparam logic [15:0] OPC_TOGGLE_VAL = 16'h7000;
   localparam logic [15:0] OPC_CLEAR_MASK = 16'hFE00;
   localparam logic [15:0] OPC_CLEAR_VAL = 16'h6A00;
   localparam logic [15:0] OPC_BRANCH_MASK = 16'hFF00;
   localparam logic [15:0] OPC_BRANCH_VAL = 16'hE400;
   localparam logic [15:0] OPC_WDOG_CLEAR = 16'h0004;
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

   typedef enum logic [2:0]
   {
      OP_NONE = 3'b000,
      OP_TOGGLE = 3'b001,
      OP_BRANCH = 3'b010,
      OP_CLEAR = 3'b011,
      OP_WDOG_CLEAR = 3'b100
   } op_kind_type;

   typedef enum logic [2:0]
   {
      PH_IDLE = 3'b000,
      PH_Q1 = 3'b001,
      PH_Q2 = 3'b010,
      PH_Q3 = 3'b011,
      PH_Q4 = 3'b100
   } phase_type;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed
   {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_type;

endpackage

/* File: src/quarter_phase_seq.sv */
`timescale 1ns/1ns
module quarter_phase_seq
   import exec_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Control
   input wire logic start_i,
   input wire logic extra_i,
   // Phase
   output phase_type phase_o,
   output logic nop_cycle_o
);

   phase_type phase_r;
   phase_type phase_nxt;
   logic nop_r;
   logic nop_nxt;

   always_comb
   begin
      phase_nxt = phase_r;
      nop_nxt = nop_r;
      case (phase_r)
         PH_IDLE:
         begin
            nop_nxt = 1'b0;
            if (start_i)
               phase_nxt = PH_Q1;
         end
         PH_Q1: phase_nxt = PH_Q2;
         PH_Q2: phase_nxt = PH_Q3;
         PH_Q3: phase_nxt = PH_Q4;
         PH_Q4:
         begin
            // A taken branch appends one cycle whose four phases are idle
            if (extra_i && !nop_r)
            begin
               phase_nxt = PH_Q1;
               nop_nxt = 1'b1;
            end
            else
            begin
               phase_nxt = PH_IDLE;
               nop_nxt = 1'b0;
            end
         end
         default:
         begin
            phase_nxt = PH_IDLE;
            nop_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         phase_r <= PH_IDLE;
         nop_r <= 1'b0;
      end
      else
      begin
         phase_r <= phase_nxt;
         nop_r <= nop_nxt;
      end
   end

   assign phase_o = phase_r;
   assign nop_cycle_o = nop_r;

   AST_PHASE_ORDER: assert property (
      @(posedge clock_i) disable iff (rst_i)
      phase_r == PH_Q1 |=> phase_r == PH_Q2 ##1 phase_r == PH_Q3
         ##1 phase_r == PH_Q4)
      else $error("quarter phases out of order");

endmodule

/* File: verif/bit_branch_clear_exec_tb_top.sv */
`timescale 1ns/1ns
module bit_branch_clear_exec_tb_top
   import exec_pkg::*;
();
   // ****************************************
   // Signals and stimulus tables
   // ****************************************
   logic clock_i;
   logic rst_i;
   apb_req_type apb_req;
   apb_rsp_type apb_rsp;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int c0;
   int cn;
   logic [31:0] d;
   logic e;
   // Addressing cases: ctrl, access select, operand, resolved address
   logic [31:0] t_ctrl [5] = '{32'h0000_0000, 32'h0000_0000,
      32'h0000_0001, 32'h0000_0001, 32'h0000_0501};
   logic t_a [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   logic [7:0] t_f [5] = '{8'h20, 8'h80, 8'h5F, 8'h60, 8'h10};
   logic [11:0] t_addr [5] = '{12'h020, 12'hF80, 12'h25F, 12'hF60,
      12'h510};
   // Branch cases from pc 100h: flag, offset, expected pc
   logic b_ovf [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
   logic [7:0] b_n [4] = '{8'h10, 8'h80, 8'h7F, 8'hFF};
   logic [31:0] b_pc [4] = '{32'h0000_0102, 32'h0000_0002,
      32'h0000_0200, 32'h0000_0100};

   bit_branch_clear_exec DUT
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .apb_req_i(apb_req),
      .apb_rsp_o(apb_rsp)
   );

   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   always @(posedge clock_i) cyc <= cyc + 1;

   // ****************************************
   // Bus and checking tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // The request stands until the rising edge where pready is seen high;
   // read data and error are taken at that edge, then it is released
   task automatic apb(input logic wr_en, input logic [11:0] addr,
      input logic [31:0] wdata, output logic [31:0] rdata,
      output logic err);
      int n;
      @(posedge clock_i);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= wr_en;
      apb_req.paddr <= addr;
      apb_req.pwdata <= wdata;
      @(posedge clock_i);
      apb_req.penable <= 1'b1;
      n = 0;
      @(posedge clock_i);
      while (apb_rsp.pready !== 1'b1 && n < 20)
      begin
         @(posedge clock_i);
         n++;
      end
      if (n == 20)
         fail_count++;
      rdata = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v,
      input logic exp_err);
      logic [31:0] r;
      logic er;
      apb(1'b1, a, v, r, er);
      check({31'h0, er}, {31'h0, exp_err});
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic er;
      apb(1'b0, a, WORD_ZERO, r, er);
      check({r[31:1], r[0] | er}, exp | {31'h0, er});
      check({31'h0, er}, WORD_ZERO);
   endtask

   task automatic poke(input logic [11:0] a, input logic [7:0] v);
      wr(REG_MEM_ADDR, {20'h0_0000, a}, 1'b0);
      wr(REG_MEM_DATA, {24'h00_0000, v}, 1'b0);
   endtask

   task automatic peek(input logic [11:0] a, input logic [7:0] v);
      wr(REG_MEM_ADDR, {20'h0_0000, a}, 1'b0);
      rd_chk(REG_MEM_DATA, {24'h00_0000, v});
   endtask

   // Probe tries a control write while busy; it must be refused
   task automatic exec_op(input logic [15:0] opc, input logic probe,
      output int cycles);
      logic [31:0] r;
      logic er;
      int t0;
      int n;
      apb(1'b1, REG_INSTR, {16'h0000, opc}, r, er);
      t0 = cyc;
      if (probe)
         wr(REG_CTRL, 32'h0000_0F00, 1'b1);
      n = 0;
      r = 32'h0000_0010;
      while (r[ST_BUSY_BIT] !== 1'b0 && n < 50)
      begin
         apb(1'b0, REG_STATUS, WORD_ZERO, r, er);
         n++;
      end
      check({31'h0, r[ST_BUSY_BIT]}, WORD_ZERO);
      cycles = cyc - t0;
   endtask

   function automatic logic [15:0] tog(logic [2:0] b, logic a,
      logic [7:0] f);
      return {4'h7, b, a, f};
   endfunction

   // ****************************************
   // Test sequence
   // ****************************************
   initial
   begin
      rst_i = 1'b1;
      apb_req = '0;
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b0;
      rd_chk(REG_STATUS, 32'h0000_000C);
      rd_chk(REG_PC, WORD_ZERO);
      wr(12'h020, WORD_ZERO, 1'b1);
      apb(1'b0, 12'h040, WORD_ZERO, d, e);
      check({31'h0, e}, 32'h0000_0001);
      wr(REG_WDOG, WORD_ZERO, 1'b1);
      wr(REG_CTRL, 32'h0000_0300, 1'b0);
      poke(12'h345, 8'h75);
      exec_op(tog(3'h4, 1'b1, 8'h45), 1'b0, cn);
      peek(12'h345, 8'h65);
      rd_chk(REG_PC, 32'h0000_0002);
      wr(REG_INDEX, 32'h0000_0200, 1'b0);
      for (int i = 0; i < 5; i++)
      begin
         wr(REG_CTRL, t_ctrl[i], 1'b0);
         poke(t_addr[i], BYTE_ZERO);
         exec_op(tog(3'h0, t_a[i], t_f[i]), 1'b0, cn);
         peek(t_addr[i], BIT_ONE);
      end
      wr(REG_CTRL, WORD_ZERO, 1'b0);
      poke(12'hF80, 8'h5A);
      wr(REG_STATUS, 32'h0000_0001, 1'b0);
      exec_op({4'h6, 3'h5, 1'b0, 8'h80}, 1'b0, cn);
      peek(12'hF80, BYTE_ZERO);
      rd_chk(REG_STATUS, 32'h0000_000F);
      for (int i = 0; i < 4; i++)
      begin
         wr(REG_STATUS, {31'h0, b_ovf[i]}, 1'b0);
         wr(REG_PC, 32'h0000_0100, 1'b0);
         exec_op({8'hE4, b_n[i]}, i == 2, cn);
         if (i == 0)
            c0 = cn;
         rd_chk(REG_PC, b_pc[i]);
         rd_chk(REG_STATUS, {28'h000_0000, 3'h6, b_ovf[i]});
         if (b_ovf[i])
            check({31'h0, cn > c0}, 32'h0000_0001);
      end
      rd_chk(REG_CTRL, WORD_ZERO);
      // Let the counter wrap so the postscaler leaves zero first
      repeat (600) @(posedge clock_i);
      apb(1'b0, REG_WDOG, WORD_ZERO, d, e);
      check({31'h0, d[15:8] != 8'h00}, 32'h0000_0001);
      exec_op(16'h0004, 1'b0, cn);
      apb(1'b0, REG_WDOG, WORD_ZERO, d, e);
      check({24'h00_0000, d[15:8]}, WORD_ZERO);
      check({31'h0, d[7:0] < 8'h40}, 32'h0000_0001);
      rd_chk(REG_STATUS, 32'h0000_000D);
      rd_chk(REG_PC, 32'h0000_0102);
      exec_op(16'hFFFF, 1'b0, cn);
      rd_chk(REG_PC, 32'h0000_0104);
      give_verdict();
   end

   // The sequence needs about a thousand cycles; this is ample margin
   initial
   begin
      #200000;
      fail_count++;
      give_verdict();
   end
endmodule
